// ===== uim_map.vh
// Purpose: Register offsets, field positions and reset values of the
//          USB interface module status and control logic.
// Assumes: 32-bit register port with byte addresses.
// Notes:   Definitions only.
`ifndef UIM_MAP_VH
`define UIM_MAP_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define UIM_OFS_RESET      8'h00
`define UIM_OFS_CONTROL    8'h04
`define UIM_OFS_DEV_ADDR   8'h08
`define UIM_OFS_OTG_FLAGS  8'h14
`define UIM_OFS_SERIAL     8'h18
`define UIM_OFS_EVT_FLAGS  8'h1C
`define UIM_OFS_STICKY     8'h20
`define UIM_OFS_MASKS      8'h24
`define UIM_OFS_FRAME      8'h28
`define UIM_OFS_PID        8'h2C
`define UIM_OFS_ENDPOINT   8'h30
`define UIM_OFS_EP_MARK    8'h34
`define UIM_OFS_OTG_MASK   8'h38
`define UIM_OFS_PWRSIG     8'h3C

// ****************************************************************
// Field positions
// ****************************************************************
`define UIM_SER_TX_SE0     3
`define UIM_SER_TX_LEVEL   2
`define UIM_SER_TX_EN_N    1
`define UIM_SER_FSLS       0
`define UIM_FLG_TOKEN      6
`define UIM_FLG_SE0        5
`define UIM_FLG_K          4
`define UIM_FLG_J          3
`define UIM_FLG_CRC16      2
`define UIM_FLG_RXACT      1
`define UIM_FLG_RXERR      0
`define UIM_EP_VALID       4
`define UIM_CTL_TOKENS     0

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define UIM_SERIAL_RST     4'h2
`define UIM_LS_SE0         2'h0
`define UIM_LS_J           2'h1
`define UIM_LS_K           2'h2
`define UIM_EP_MARK_OR     5'h10
`define UIM_PID_TOKEN_MASK 2'h1

`endif

// ===== uim_status_regs.v
// Purpose: Status and control registers of the USB interface module:
//          session flags, serial line drive, event flags with hold
//          select, notification ports, frame count, PID and endpoint.
// Assumes: Transceiver inputs are asynchronous and pass a three-stage
//          synchroniser; packet decode strobes come from core logic.
// Notes:   Registers reached over a simple 32-bit read/write port.
//
// What this block does
// - Session flags read-only, mirror six transceiver bits, zero after reset.
// - Serial bits 6,5,4 read-only: differential, D-minus, D-plus receivers.
// - Serial bit 3 drives SE0 request, bit 2 transmit level; reset zero.
// - Serial bit 1 is active-low transmit enable, resets to one.
// - Serial bit 0 selects full/low-speed serial mode, resets zero.
// - Non-held flags 6 to 2 clear when the next packet begins.
// - Flag 6 set on good token matching stored device address.
// - Flags 5,4,3 set on line state SE0, K, J.
// - Flag 2 set when a data packet fails CRC16.
// - Flags 1,0 follow receive-active and receive-error inputs.
// - Seven hold bits; held flag keeps value until software writes one.
// - Non-held flags update freely from their sources.
// - Four 8-bit masks OR selected flags onto four notification ports.
// - Eleven-bit writable frame counter held as one field, bits 10:0, reset zero.
// - Capture the 4-bit PID of the last accepted token.
// - Store last endpoint, bit 4 marks it valid.
// - Marked endpoints delivered on receive port ORed with 0x10.
// - Only packets for the stored 7-bit device address pass on.
// - Token decoding active only while control bit 0 is set.
// - Any write to reset register returns registers to reset; rx_endp, reg_rdata and the synchronisers keep their values.
`timescale 1ns/1ps
`include "uim_map.vh"

module uim_status_regs #(
	parameter FLAGS = 7
) (
	input  wire        ref_clk,
	input  wire        rst,
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [7:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	output reg  [31:0] reg_rdata,
	input  wire [5:0]  otg_in,
	input  wire        diff_receiver_state,
	input  wire        dminus_receiver_state,
	input  wire        dplus_receiver_state,
	input  wire [1:0]  line_state,
	input  wire        rx_active,
	input  wire        rx_error,
	input  wire        pkt_start,
	input  wire        tok_valid,
	input  wire [3:0]  tok_pid,
	input  wire [6:0]  tok_addr,
	input  wire [3:0]  tok_endp,
	input  wire        data_crc_fail,
	output reg         serial_tx_single_ended_zero,
	output reg         serial_tx_level,
	output reg         serial_tx_enable_low,
	output reg         full_low_speed_serial_select,
	output reg  [3:0]  notify_port,
	output reg         rx_endp_valid,
	output reg  [4:0]  rx_endp
);

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	// Three stages each; a change counts once stages two and three agree.
	// The line-state stages rest at J, the idle bus level, so that leaving
	// reset does not report a false single-ended zero event.
	wire [5:0] otg_s;
	wire [2:0] rcv_s;
	wire [1:0] ls_s;
	wire [1:0] rx_s;
	wire       rxact_s  = rx_s[1];
	wire       rxerr_s  = rx_s[0];
	wire       soft_rst = reg_wr && (reg_addr == `UIM_OFS_RESET);

	uim_sync3 #(
		.W      (6)
	) i_sync_otg (
		.ref_clk(ref_clk),
		.rst    (rst),
		.d      (otg_in),
		.sync_q (otg_s)
	);

	uim_sync3 #(
		.W      (3)
	) i_sync_rcv (
		.ref_clk(ref_clk),
		.rst    (rst),
		.d      ({diff_receiver_state, dminus_receiver_state,
			dplus_receiver_state}),
		.sync_q (rcv_s)
	);

	uim_sync3 #(
		.W      (2),
		.RST_VAL(`UIM_LS_J)
	) i_sync_ls (
		.ref_clk(ref_clk),
		.rst    (rst),
		.d      (line_state),
		.sync_q (ls_s)
	);

	uim_sync3 #(
		.W      (2)
	) i_sync_rx (
		.ref_clk(ref_clk),
		.rst    (rst),
		.d      ({rx_active, rx_error}),
		.sync_q (rx_s)
	);

	// ****************************************************************
	// Register state
	// ****************************************************************
	reg [5:0]       otg_q;
	reg [3:0]       serial_q;
	reg [FLAGS-1:0] flags_q;
	reg [FLAGS-1:0] hold_q;
	reg [31:0]      masks_q;
	reg [10:0]      frame_q;
	reg [3:0]       pid_q;
	reg [4:0]       endp_q;
	reg [15:0]      mark_q;
	reg [31:0]      otg_mask_q;
	reg [8:0]       pwrsig_q;
	reg [6:0]       dev_addr_q;
	reg [7:0]       ctl_q;

	wire wr_hit_flags = reg_wr && (reg_addr == `UIM_OFS_EVT_FLAGS);
	wire tok_ok = tok_valid && ctl_q[`UIM_CTL_TOKENS]
		&& (tok_addr == dev_addr_q);

	// Raw flag sources this cycle.
	reg [FLAGS-1:0] src;
	always @* begin
		src = {FLAGS{1'b0}};
		src[`UIM_FLG_TOKEN] = tok_ok;
		src[`UIM_FLG_SE0]   = (ls_s == `UIM_LS_SE0);
		src[`UIM_FLG_K]     = (ls_s == `UIM_LS_K);
		src[`UIM_FLG_J]     = (ls_s == `UIM_LS_J);
		src[`UIM_FLG_CRC16] = data_crc_fail;
		src[`UIM_FLG_RXACT] = rxact_s;
		src[`UIM_FLG_RXERR] = rxerr_s;
	end

	// Event flags latch their set; level flags follow. Packet start clears
	// non-held bits, but a set arriving together still wins.
	localparam [FLAGS-1:0] LEVEL_BITS = 7'h03;
	reg [FLAGS-1:0] flags_d;
	reg [FLAGS-1:0] free_d;
	reg [FLAGS-1:0] wclr;
	always @* begin
		wclr = wr_hit_flags ? reg_wdata[FLAGS-1:0] : {FLAGS{1'b0}};
		free_d = (LEVEL_BITS & src) | (~LEVEL_BITS &
			((pkt_start ? {FLAGS{1'b0}} : flags_q) | src));
		flags_d = (hold_q & ((flags_q & ~wclr) | src))
			| (~hold_q & free_d);
	end

	// ****************************************************************
	// Register writes and captures
	// ****************************************************************
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			otg_q      <= 6'h00;
			serial_q   <= `UIM_SERIAL_RST;
			flags_q    <= {FLAGS{1'b0}};
			hold_q     <= {FLAGS{1'b0}};
			masks_q    <= 32'h00000000;
			frame_q    <= 11'h000;
			pid_q      <= 4'h0;
			endp_q     <= 5'h00;
			mark_q     <= 16'h0000;
			otg_mask_q <= 32'h00000000;
			pwrsig_q   <= 9'h000;
			dev_addr_q <= 7'h00;
			ctl_q      <= 8'h00;
		end else if (soft_rst) begin
			otg_q      <= 6'h00;
			serial_q   <= `UIM_SERIAL_RST;
			flags_q    <= {FLAGS{1'b0}};
			hold_q     <= {FLAGS{1'b0}};
			masks_q    <= 32'h00000000;
			frame_q    <= 11'h000;
			pid_q      <= 4'h0;
			endp_q     <= 5'h00;
			mark_q     <= 16'h0000;
			otg_mask_q <= 32'h00000000;
			pwrsig_q   <= 9'h000;
			dev_addr_q <= 7'h00;
			ctl_q      <= 8'h00;
		end else begin
			otg_q   <= otg_s;
			flags_q <= flags_d;
			if (tok_ok) begin
				pid_q  <= tok_pid;
				endp_q <= {1'b1, tok_endp};
			end
			if (reg_wr) begin
				case (reg_addr)
				`UIM_OFS_CONTROL:  ctl_q <= reg_wdata[7:0];
				`UIM_OFS_DEV_ADDR: dev_addr_q <= reg_wdata[6:0];
				`UIM_OFS_SERIAL:   serial_q <= reg_wdata[3:0];
				`UIM_OFS_STICKY:   hold_q <= reg_wdata[FLAGS-1:0];
				`UIM_OFS_MASKS:    masks_q <= reg_wdata;
				`UIM_OFS_FRAME:    frame_q <= reg_wdata[10:0];
				`UIM_OFS_EP_MARK:  mark_q <= reg_wdata[15:0];
				`UIM_OFS_OTG_MASK: otg_mask_q <= reg_wdata;
				`UIM_OFS_PWRSIG:   pwrsig_q <= reg_wdata[8:0];
				default: begin
				end
				endcase
			end
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	integer i;
	reg [3:0] notify_d;
	always @* begin
		notify_d = 4'h0;
		for (i = 0; i < 4; i = i + 1) begin
			notify_d[i] = |(masks_q[i*8 +: FLAGS] & flags_d);
		end
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			serial_tx_single_ended_zero  <= 1'b0;
			serial_tx_level              <= 1'b0;
			serial_tx_enable_low         <= 1'b1;
			full_low_speed_serial_select <= 1'b0;
			notify_port                  <= 4'h0;
			rx_endp_valid                <= 1'b0;
			rx_endp                      <= 5'h00;
			reg_rdata                    <= 32'h00000000;
		end else begin
			serial_tx_single_ended_zero  <= serial_q[`UIM_SER_TX_SE0];
			serial_tx_level              <= serial_q[`UIM_SER_TX_LEVEL];
			serial_tx_enable_low         <= serial_q[`UIM_SER_TX_EN_N];
			full_low_speed_serial_select <= serial_q[`UIM_SER_FSLS];
			notify_port <= soft_rst ? 4'h0 : notify_d;
			rx_endp_valid <= tok_ok && !soft_rst;
			if (tok_ok)
				rx_endp <= {1'b0, tok_endp} |
					(mark_q[tok_endp] ? `UIM_EP_MARK_OR : 5'h00);
			if (reg_rd) begin
				case (reg_addr)
				`UIM_OFS_CONTROL:   reg_rdata <= {24'h000000, ctl_q};
				`UIM_OFS_DEV_ADDR:  reg_rdata <= {25'h0000000, dev_addr_q};
				`UIM_OFS_OTG_FLAGS: reg_rdata <= {26'h0000000, otg_q};
				`UIM_OFS_SERIAL:    reg_rdata <= {25'h0000000, rcv_s,
					serial_q};
				`UIM_OFS_EVT_FLAGS: reg_rdata <= {25'h0000000, flags_q};
				`UIM_OFS_STICKY:    reg_rdata <= {25'h0000000, hold_q};
				`UIM_OFS_MASKS:     reg_rdata <= masks_q;
				`UIM_OFS_FRAME:     reg_rdata <= {21'h000000, frame_q};
				`UIM_OFS_PID:       reg_rdata <= {28'h0000000, pid_q};
				`UIM_OFS_ENDPOINT:  reg_rdata <= {27'h0000000, endp_q};
				`UIM_OFS_EP_MARK:   reg_rdata <= {16'h0000, mark_q};
				`UIM_OFS_OTG_MASK:  reg_rdata <= otg_mask_q;
				`UIM_OFS_PWRSIG:    reg_rdata <= {23'h000000, pwrsig_q};
				default:            reg_rdata <= 32'h00000000;
				endcase
			end
		end
	end

endmodule

// ****************************************************************
// Three-stage synchroniser with agreement filter
// ****************************************************************
// The extra stage costs a cycle of latency but keeps a value that has
// not yet settled from reaching the flags or the status reads.
module uim_sync3 #(
	parameter         W       = 1,
	parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
	input  wire         ref_clk,
	input  wire         rst,
	input  wire [W-1:0] d,
	output reg  [W-1:0] sync_q
);

	reg  [W-1:0] s1_q;
	reg  [W-1:0] s2_q;
	reg  [W-1:0] s3_q;
	wire [W-1:0] agree = ~(s2_q ^ s3_q);

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s1_q   <= RST_VAL;
			s2_q   <= RST_VAL;
			s3_q   <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			s1_q   <= d;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			sync_q <= (agree & s3_q) | (~agree & sync_q);
		end
	end

endmodule

// ===== uim_status_regs_asserts.sv
// Purpose: Port-level checks of the USB interface status registers.
// Assumes: One core clock and an asynchronous active-high reset.
// Notes:   Bound to every instance of the design's top module.
`timescale 1ns/1ps
module uim_status_regs_asserts (
	input logic        ref_clk,
	input logic        rst,
	input logic        reg_wr,
	input logic        reg_rd,
	input logic [7:0]  reg_addr,
	input logic [31:0] reg_wdata,
	input logic [31:0] reg_rdata,
	input logic        tok_valid,
	input logic [3:0]  tok_endp,
	input logic        serial_tx_single_ended_zero,
	input logic        serial_tx_level,
	input logic        serial_tx_enable_low,
	input logic        full_low_speed_serial_select,
	input logic [3:0]  notify_port,
	input logic        rx_endp_valid,
	input logic [4:0]  rx_endp
);
	// ****************************************************************
	// Sequences and properties
	// ****************************************************************
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence ser_wr; reg_wr && reg_addr == 8'h18; endsequence
	sequence rd_at(a); reg_rd && reg_addr == a; endsequence
	reset_values_a: assert property ($fell(rst) |-> serial_tx_enable_low
		&& notify_port == 4'h0 && !rx_endp_valid) else $error("reset value");
	soft_reset_a: assert property (reg_wr && reg_addr == 8'h00 |=> ##1
		serial_tx_enable_low && notify_port == 4'h0) else $error("soft reset");
	tx_drive_a: assert property (ser_wr |-> ##2
		serial_tx_single_ended_zero == $past(reg_wdata[3], 2)
		&& serial_tx_level == $past(reg_wdata[2], 2)) else $error("tx drive");
	tx_enable_a: assert property (ser_wr |-> ##2
		serial_tx_enable_low == $past(reg_wdata[1], 2)) else $error("tx enable");
	fsls_select_a: assert property (ser_wr |-> ##2
		full_low_speed_serial_select == $past(reg_wdata[0], 2))
		else $error("serial select");
	otg_reserved_a: assert property (rd_at(8'h14) |=>
		reg_rdata[31:6] == 26'h0) else $error("session flag width");
	frame_width_a: assert property (rd_at(8'h28) |=>
		reg_rdata[31:11] == 21'h0) else $error("frame count width");
	unmapped_read_a: assert property (rd_at(8'h44) |=>
		reg_rdata == 32'h0) else $error("unmapped read");
	endp_capture_a: assert property (rx_endp_valid |-> $past(tok_valid)
		&& rx_endp[3:0] == $past(tok_endp)) else $error("endpoint capture");
endmodule

bind uim_status_regs uim_status_regs_asserts i_chk (.ref_clk(ref_clk),
	.rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tok_valid(tok_valid),
	.tok_endp(tok_endp),
	.serial_tx_single_ended_zero(serial_tx_single_ended_zero),
	.serial_tx_level(serial_tx_level),
	.serial_tx_enable_low(serial_tx_enable_low),
	.full_low_speed_serial_select(full_low_speed_serial_select),
	.notify_port(notify_port), .rx_endp_valid(rx_endp_valid),
	.rx_endp(rx_endp));

// ===== uim_status_regs_tb.sv
// Purpose: Register-level test of the USB interface status registers.
// Assumes: Loop-back transceiver model on the serial line.
// Notes:   Transceiver inputs are waited out for six cycles.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module uim_status_regs_tb;
	// ****************************************************************
	// Signals and instances
	// ****************************************************************
	logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, pkt_start = 0;
	logic tok_valid = 0, data_crc_fail = 0, rx_active = 0, rx_error = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [5:0] otg_in = 6'h00;
	logic [3:0] tok_pid = 4'h0, tok_endp = 4'h0;
	logic [6:0] tok_addr = 7'h00;
	wire [31:0] reg_rdata;
	wire dif, dm, dp, se0, lvl, en_n, fsls, ev;
	wire [1:0] ls;
	wire [3:0] np;
	wire [4:0] ep;
	int n_errors = 0, compares = 0;
	always #2 ref_clk = ~ref_clk;
	uim_status_regs i_dut (.ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .otg_in(otg_in), .diff_receiver_state(dif),
		.dminus_receiver_state(dm), .dplus_receiver_state(dp),
		.line_state(ls), .rx_active(rx_active), .rx_error(rx_error),
		.pkt_start(pkt_start), .tok_valid(tok_valid), .tok_pid(tok_pid),
		.tok_addr(tok_addr), .tok_endp(tok_endp),
		.data_crc_fail(data_crc_fail), .serial_tx_single_ended_zero(se0),
		.serial_tx_level(lvl), .serial_tx_enable_low(en_n),
		.full_low_speed_serial_select(fsls), .notify_port(np),
		.rx_endp_valid(ev), .rx_endp(ep));
	uim_xcvr_model i_xcvr (.tx_se0(se0), .tx_level(lvl), .tx_en_low(en_n),
		.diff_out(dif), .dminus_out(dm), .dplus_out(dp), .line_state(ls));
	// ****************************************************************
	// Access tasks
	// ****************************************************************
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task wr(input [7:0] a, input [31:0] d);
		cyc(1);
		reg_wr = 1;
		reg_addr = a;
		reg_wdata = d;
		cyc(1);
		reg_wr = 0;
	endtask
	task rd(input [7:0] a, input [31:0] e, input [31:0] m);
		cyc(1);
		reg_rd = 1;
		reg_addr = a;
		cyc(1);
		reg_rd = 0;
		`CHK(reg_rdata & m, e)
	endtask
	task ser(input [3:0] d);
		wr(8'h18, {28'h0, d});
		cyc(1);
		`CHK({se0, lvl, en_n, fsls}, d)
		cyc(6);
	endtask
	task pkt;
		cyc(1);
		pkt_start = 1;
		cyc(1);
		pkt_start = 0;
	endtask
	task tok(input [6:0] a, input [3:0] e, p, input v, input [4:0] x);
		cyc(1);
		{tok_valid, tok_addr, tok_endp, tok_pid} = {1'b1, a, e, p};
		cyc(1);
		tok_valid = 0;
		`CHK({ev, ep}, {v, x})
	endtask
	task complete_run;
		$display("mismatches %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		#20000;
		n_errors++;
		complete_run;
	end
	initial begin
		cyc(8);
		rst = 0;
		cyc(6);
		rd(8'h18, 32'h52, 32'hFFFFFFFF);
		otg_in = 6'h2A;
		cyc(6);
		rd(8'h14, 32'h2A, 32'hFFFFFFFF);
		ser(4'h9);
		ser(4'h0);
		ser(4'h4);
		rd(8'h18, 32'h54, 32'h7F);
		rd(8'h1C, 32'h38, 32'h38);
		pkt;
		rd(8'h1C, 32'h08, 32'h38);
		wr(8'h20, 32'h20);
		rd(8'h20, 32'h20, 32'hFFFFFFFF);
		ser(4'h9);
		ser(4'h4);
		pkt;
		rd(8'h1C, 32'h28, 32'h38);
		wr(8'h1C, 32'h20);
		rd(8'h1C, 32'h08, 32'h38);
		wr(8'h24, 32'h08002008);
		cyc(2);
		`CHK(np, 4'h9)
		{rx_active, rx_error} = 2'h3;
		cyc(1);
		data_crc_fail = 1;
		cyc(1);
		data_crc_fail = 0;
		cyc(6);
		rd(8'h1C, 32'h07, 32'h07);
		{rx_active, rx_error} = 2'h0;
		cyc(6);
		rd(8'h1C, 32'h00, 32'h03);
		wr(8'h08, 32'h15);
		wr(8'h04, 32'h01);
		wr(8'h34, 32'h0008);
		tok(7'h15, 4'h3, 4'h9, 1'b1, 5'h13);
		rd(8'h1C, 32'h40, 32'h40);
		rd(8'h30, 32'h13, 32'hFFFFFFFF);
		tok(7'h15, 4'h2, 4'h5, 1'b1, 5'h02);
		tok(7'h16, 4'h4, 4'hA, 1'b0, 5'h02);
		wr(8'h04, 32'h00);
		tok(7'h15, 4'h4, 4'hA, 1'b0, 5'h02);
		wr(8'h2C, 32'hF);
		rd(8'h2C, 32'h5, 32'hFFFFFFFF);
		wr(8'h28, 32'hFFFFFFFF);
		rd(8'h28, 32'h7FF, 32'hFFFFFFFF);
		wr(8'h3C, 32'hFFFFFFFF);
		rd(8'h3C, 32'h1FF, 32'hFFFFFFFF);
		rd(8'h44, 32'h0, 32'hFFFFFFFF);
		wr(8'h00, 32'h0);
		cyc(8);
		rd(8'h28, 32'h0, 32'hFFFFFFFF);
		rd(8'h3C, 32'h0, 32'hFFFFFFFF);
		rd(8'h18, 32'h52, 32'h7F);
		`CHK({se0, lvl, en_n, fsls, np}, 8'h20)
		complete_run;
	end
endmodule

// ===== uim_xcvr_model.sv
// Purpose: Loop-back model of the transceiver's serial line.
// Assumes: Transmit drive reaches the receivers after DLY ns.
// Notes:   With transmit disabled the line rests in the J state.
`timescale 1ns/1ps
module uim_xcvr_model #(
	parameter DLY = 3
) (
	input  wire       tx_se0,
	input  wire       tx_level,
	input  wire       tx_en_low,
	output wire       diff_out,
	output wire       dminus_out,
	output wire       dplus_out,
	output wire [1:0] line_state
);
	// ****************************************************************
	// Line drive
	// ****************************************************************
	// An idle full-speed line is pulled to J, so idle reads as a one.
	wire se0 = !tx_en_low && tx_se0;
	wire lvl = tx_en_low || tx_level;
	assign #(DLY) diff_out = lvl;
	assign #(DLY) dplus_out = !se0 && lvl;
	assign #(DLY) dminus_out = !se0 && !lvl;
	assign #(DLY) line_state = se0 ? 2'h0 : (lvl ? 2'h1 : 2'h2);
endmodule
